// File: gws_guest_model.sv
`timescale 1ns/1ns
module gws_guest_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Block and bench control
  input wire logic guest_running,
  input wire logic [7:0] exit_delay,
  input wire logic [63:0] reason,
  // Guest events
  output logic guest_instr_done,
  output logic exit_req,
  output logic [63:0] exit_reason
);
  logic [7:0] cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !guest_running) cnt_reg <= 8'h00;
    else cnt_reg <= cnt_reg + 8'h01;
  end
  assign guest_instr_done = guest_running && cnt_reg == 8'h01;
  // Held until the block leaves the guest
  assign exit_req = guest_running && cnt_reg >= exit_delay;
  // Reason is garbage outside a request
  assign exit_reason = exit_req ? reason : ~reason;
endmodule

// File: gws_pkg.sv
package gws_pkg;
  localparam int XLEN = 64;
  localparam int HI_LO = 32;
  localparam int HI_HI = 63;
  localparam int PROTECTION_ENABLE_BIT = 0;
  localparam int NO_WRITETHROUGH_BIT = 29;
  localparam int CACHE_DISABLE_BIT = 30;
  localparam int PAGING_BIT = 31;
  localparam int PHYS_ADDR_EXT_BIT = 5;
  localparam int LONG_MODE_ENABLE = 8;
  localparam int LONG_MODE_ACTIVE = 10;
  localparam int VIRT_ENABLE_BIT = 12;
  localparam int VA_MSB = 47;
  localparam int CPL_W = 2;
  localparam int EXIT_W = 64;
  localparam int DR7_BP_W = 8;
  localparam int PA_W = 52;
  localparam int ADDRESS_SPACE_ID_W = 32;
  localparam int NSEG = 8;
  localparam logic [63:0] BAD_STATE_EXIT_CODE = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] CR3_MBZ_DEF = 64'hFFF0_0000_0000_0000;
  localparam logic [63:0] CR4_MBZ_DEF = 64'hFFFF_FFFF_FF80_0000;
  localparam logic [63:0] EFER_MBZ_DEF = 64'hFFFF_FFFF_FFFF_0200;
  localparam logic [63:0] PAGE_DIR_POINTER_ENTRY_MBZ_DEF = 64'hFFF0_0000_0000_01E6;
  localparam logic [1:0] CPL_ZERO = 2'h0;
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_GP0 = 2'h1;
  localparam logic [1:0] EXC_UD = 2'h2;
  localparam logic [1:0] OP_ENTRY = 2'h0;
  localparam logic [1:0] OP_SAVE = 2'h1;
  localparam logic [1:0] OP_LOAD = 2'h2;
  typedef enum logic [2:0] {
    GWS_IDLE = 3'b000,
    GWS_CHECK = 3'b001,
    GWS_GUEST = 3'b010,
    GWS_EXIT = 3'b011,
    GWS_HOSTCHK = 3'b100,
    GWS_SHUT = 3'b101
  } gws_state_e;
endpackage

// File: gws_world_switch.sv
`timescale 1ns/1ns
module gws_world_switch #(
  parameter logic [63:0] CR3_MBZ = gws_pkg::CR3_MBZ_DEF,
  parameter logic [63:0] CR4_MBZ = gws_pkg::CR4_MBZ_DEF,
  parameter logic [63:0] EFER_MBZ = gws_pkg::EFER_MBZ_DEF,
  parameter logic [63:0] PAGE_DIR_POINTER_ENTRY_MBZ = gws_pkg::PAGE_DIR_POINTER_ENTRY_MBZ_DEF,
  parameter int MAX_PA_W = gws_pkg::PA_W,
  parameter bit LONG_MODE_OK = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [1:0] instr_op,
  input wire logic [1:0] host_cpl,
  input wire logic host_prot_mode,
  input wire logic [63:0] host_efer,
  input wire logic host_rf,
  input wire logic host_tf,
  // Merged guest state from control block
  input wire logic [63:0] g_cr0,
  input wire logic [63:0] g_cr3,
  input wire logic [63:0] g_cr4,
  input wire logic [63:0] g_efer,
  input wire logic [63:0] g_dr6,
  input wire logic [63:0] g_dr7,
  input wire logic g_cs_l,
  input wire logic g_cs_d,
  input wire logic g_rf,
  input wire logic g_tf,
  input wire logic entry_intercept_bit,
  input wire logic [31:0] g_address_space_id,
  input wire logic inject_bad,
  input wire logic [63:0] msr_tbl_end,
  input wire logic [63:0] io_tbl_end,
  input wire logic [63:0] seg_base_in,
  input wire logic [2:0] seg_idx_in,
  input wire logic seg_load,
  // Guest run and exit
  input wire logic guest_instr_done,
  input wire logic exit_req,
  input wire logic [63:0] exit_reason,
  // Host reload results
  input wire logic host_pae,
  input wire logic [63:0] host_page_dir_pointer_entry,
  input wire logic host_seg_fault,
  input wire logic host_state_bad,
  input wire logic host_ip_bad,
  // Status and effects
  output logic guest_running,
  output logic global_irq_flag,
  output logic [63:0] exit_reason_field,
  output logic exit_wb_pulse,
  output logic xctx_move_pulse,
  output logic xctx_dir_load,
  output logic [1:0] exc_raise,
  output logic shutdown,
  output logic host_gp,
  output logic host_db_trap,
  output logic host_rf_out,
  output logic guest_bp_suppress,
  output logic guest_trace_trap,
  output logic intercepts_on,
  output logic [31:0] cur_address_space_id,
  output logic virt_irq,
  output logic virtual_irq_mask_ctl,
  output logic [63:0] timestamp_offset,
  output logic force_pe,
  output logic virtual8086_flag,
  output logic [1:0] current_privilege_level,
  output logic [7:0] debug_control_bp_en,
  output logic [63:0] seg_base_out
);

  function automatic logic [63:0] canon(input logic [63:0] b);
    canon = {{(64 - gws_pkg::VA_MSB){b[gws_pkg::VA_MSB]}},
             b[gws_pkg::VA_MSB-1:0]};
  endfunction

  function automatic logic hi_nz(input logic [63:0] v);
    hi_nz = |v[gws_pkg::HI_HI:gws_pkg::HI_LO];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  gws_pkg::gws_state_e state_reg, state_next;
  logic [63:0] seg_reg [gws_pkg::NSEG];
  logic first_reg;

  // Host privilege and mode checks, then guest state checks taken straight from the inputs
  wire priv_ok = (host_cpl == gws_pkg::CPL_ZERO);
  wire mode_ok = host_prot_mode & host_efer[gws_pkg::VIRT_ENABLE_BIT];
  wire lme = g_efer[gws_pkg::LONG_MODE_ENABLE];
  wire pg = g_cr0[gws_pkg::PAGING_BIT];
  wire pae = g_cr4[gws_pkg::PHYS_ADDR_EXT_BIT];
  wire [63:0] pa_max = 64'h1 << MAX_PA_W;
  wire chk_svme = ~g_efer[gws_pkg::VIRT_ENABLE_BIT];
  wire chk_cdnw = ~g_cr0[gws_pkg::CACHE_DISABLE_BIT] & g_cr0[gws_pkg::NO_WRITETHROUGH_BIT];
  wire chk_hi = hi_nz(g_cr0) | hi_nz(g_dr6) | hi_nz(g_dr7);
  wire chk_mbz = |(g_cr3 & CR3_MBZ) | |(g_cr4 & CR4_MBZ)
               | |(g_efer & EFER_MBZ);
  wire chk_lm = ~LONG_MODE_OK & (lme | g_efer[gws_pkg::LONG_MODE_ACTIVE]);
  // PE clear with PG set alone is not flagged here
  wire chk_lmpg = lme & pg & (~pae | ~g_cr0[gws_pkg::PROTECTION_ENABLE_BIT]);
  wire chk_csld = lme & pg & pae & g_cs_l & g_cs_d;
  wire chk_ctl = ~entry_intercept_bit | (g_address_space_id == '0)
               | inject_bad;
  wire chk_tbl = (msr_tbl_end >= pa_max) | (io_tbl_end >= pa_max);
  // Inputs are the merged state after clean-field resolution
  wire guest_bad = chk_svme | chk_cdnw | chk_hi | chk_mbz | chk_lm
                 | chk_lmpg | chk_csld | chk_ctl | chk_tbl;
  wire page_dir_pointer_entry_bad = host_pae & (|(host_page_dir_pointer_entry & PAGE_DIR_POINTER_ENTRY_MBZ));
  wire host_fail = host_seg_fault | page_dir_pointer_entry_bad | host_state_bad;
  wire issue = instr_valid & (state_reg == gws_pkg::GWS_IDLE);
  wire [1:0] fault = ~priv_ok ? gws_pkg::EXC_GP0
                   : ~mode_ok ? gws_pkg::EXC_UD : gws_pkg::EXC_NONE;
  wire go_entry = issue & (instr_op == gws_pkg::OP_ENTRY)
                & (fault == gws_pkg::EXC_NONE);
  wire go_xctx = issue & (instr_op != gws_pkg::OP_ENTRY)
               & (fault == gws_pkg::EXC_NONE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      gws_pkg::GWS_IDLE: if (go_entry) state_next = gws_pkg::GWS_CHECK;
      gws_pkg::GWS_CHECK: begin
        // Guest starts only after every check has passed
        if (guest_bad) state_next = gws_pkg::GWS_EXIT;
        else state_next = gws_pkg::GWS_GUEST;
      end
      gws_pkg::GWS_GUEST: if (exit_req) state_next = gws_pkg::GWS_EXIT;
      gws_pkg::GWS_EXIT: state_next = gws_pkg::GWS_HOSTCHK;
      gws_pkg::GWS_HOSTCHK: begin
        if (host_fail) state_next = gws_pkg::GWS_SHUT;
        else state_next = gws_pkg::GWS_IDLE;
      end
      gws_pkg::GWS_SHUT: state_next = gws_pkg::GWS_SHUT;
      default: state_next = gws_pkg::GWS_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  wire in_check = (state_reg == gws_pkg::GWS_CHECK);
  wire in_exit = (state_reg == gws_pkg::GWS_EXIT);
  wire in_hchk = (state_reg == gws_pkg::GWS_HOSTCHK);
  wire enter_guest = in_check & ~guest_bad;
  wire [63:0] reason_next = guest_bad & in_check
                          ? gws_pkg::BAD_STATE_EXIT_CODE : exit_reason;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= gws_pkg::GWS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Segment bases are canonical whenever loaded
  always_ff @(posedge sys_clk) begin
    if (seg_load & (in_check | in_exit | go_xctx)) begin
      seg_reg[seg_idx_in] <= canon(seg_base_in);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seg_base_out <= '0;
    end else begin
      seg_base_out <= canon(seg_reg[seg_idx_in]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      guest_running <= 1'b0;
      global_irq_flag <= 1'b1;
      exit_reason_field <= '0;
      exit_wb_pulse <= 1'b0;
      shutdown <= 1'b0;
      host_gp <= 1'b0;
      host_db_trap <= 1'b0;
      host_rf_out <= 1'b0;
    end else begin
      guest_running <= enter_guest | (state_reg == gws_pkg::GWS_GUEST)
                       & ~exit_req;
      if (enter_guest) global_irq_flag <= 1'b1;
      else if (in_exit) global_irq_flag <= 1'b0;
      if ((in_check & guest_bad) | (state_reg == gws_pkg::GWS_GUEST)
          & exit_req) begin
        exit_reason_field <= reason_next;
      end
      exit_wb_pulse <= in_exit;
      if (in_hchk & host_fail) shutdown <= 1'b1;
      host_gp <= in_hchk & ~host_fail & host_ip_bad;
      // Entry completes as one host instruction at exit
      host_db_trap <= in_hchk & ~host_fail & host_tf;
      if (go_entry) host_rf_out <= host_rf;
      else if (in_hchk) host_rf_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      first_reg <= 1'b0;
      guest_bp_suppress <= 1'b0;
      guest_trace_trap <= 1'b0;
    end else begin
      if (enter_guest) first_reg <= 1'b1;
      else if (guest_instr_done | exit_req) first_reg <= 1'b0;
      // Guest flags only; host flags are kept apart
      if (enter_guest) guest_bp_suppress <= g_rf;
      else if (guest_instr_done) guest_bp_suppress <= 1'b0;
      guest_trace_trap <= first_reg & guest_instr_done & g_tf;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      intercepts_on <= 1'b0;
      cur_address_space_id <= '0;
      virt_irq <= 1'b0;
      virtual_irq_mask_ctl <= 1'b0;
      timestamp_offset <= '0;
    end else if (enter_guest) begin
      intercepts_on <= 1'b1;
      cur_address_space_id <= g_address_space_id;
      virt_irq <= 1'b1;
      virtual_irq_mask_ctl <= 1'b1;
      timestamp_offset <= '0;
    end else if (in_exit) begin
      intercepts_on <= 1'b0;
      cur_address_space_id <= '0;
      virt_irq <= 1'b0;
      virtual_irq_mask_ctl <= 1'b0;
      timestamp_offset <= '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      force_pe <= 1'b0;
      virtual8086_flag <= 1'b0;
      current_privilege_level <= gws_pkg::CPL_ZERO;
      debug_control_bp_en <= '1;
      xctx_move_pulse <= 1'b0;
      xctx_dir_load <= 1'b0;
      exc_raise <= gws_pkg::EXC_NONE;
    end else begin
      force_pe <= in_exit | (force_pe & ~enter_guest);
      if (in_exit) begin
        virtual8086_flag <= 1'b0;
        current_privilege_level <= gws_pkg::CPL_ZERO;
        debug_control_bp_en <= '0;
      end else if (enter_guest) begin
        debug_control_bp_en <= g_dr7[gws_pkg::DR7_BP_W-1:0];
      end
      xctx_move_pulse <= go_xctx;
      if (go_xctx) xctx_dir_load <= (instr_op == gws_pkg::OP_LOAD);
      exc_raise <= issue ? fault : gws_pkg::EXC_NONE;
    end
  end

endmodule

// File: gws_world_switch_props.sv
`timescale 1ns/1ns
module gws_world_switch_props (
  input wire logic sys_clk, sys_rst, instr_valid, host_prot_mode,
  input wire logic [1:0] instr_op, host_cpl, exc_raise,
  input wire logic [1:0] current_privilege_level,
  input wire logic [63:0] host_efer, seg_base_in, seg_base_out,
  input wire logic [63:0] timestamp_offset,
  input wire logic [31:0] cur_address_space_id,
  input wire logic [7:0] debug_control_bp_en,
  input wire logic [2:0] seg_idx_in,
  input wire logic entry_intercept_bit, host_seg_fault, seg_load,
  input wire logic guest_running, global_irq_flag, exit_wb_pulse,
  input wire logic shutdown, intercepts_on, virt_irq, force_pe,
  input wire logic virtual_irq_mask_ctl, virtual8086_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [63:0] canon_reg;
  always_ff @(posedge sys_clk) begin
    if (seg_load) canon_reg <= {{16{seg_base_in[47]}}, seg_base_in[47:0]};
  end
  sequence s_issue;
    instr_valid && !guest_running && instr_op != 2'h3;
  endsequence
  sequence s_host_ok;
    host_cpl == 2'h0 && host_prot_mode && host_efer[gws_pkg::VIRT_ENABLE_BIT];
  endsequence
  sequence s_bad_entry;
    s_issue ##0 s_host_ok ##0 instr_op == gws_pkg::OP_ENTRY
      && !entry_intercept_bit;
  endsequence
  AST_GP0: assert property (s_issue ##0 host_cpl != 2'h0 && host_prot_mode
    && host_efer[gws_pkg::VIRT_ENABLE_BIT] |=> exc_raise == gws_pkg::EXC_GP0)
    else $error("privileged op did not raise GP0");
  AST_UD: assert property (s_issue ##0 host_cpl == 2'h0 &&
    !(host_prot_mode && host_efer[gws_pkg::VIRT_ENABLE_BIT])
    |=> exc_raise == gws_pkg::EXC_UD) else $error("missing UD");
  AST_NO_EXC: assert property (s_issue ##0 s_host_ok
    |=> exc_raise == gws_pkg::EXC_NONE) else $error("spurious exception");
  AST_BAD_EXIT: assert property (s_bad_entry |-> ##[1:6] exit_wb_pulse)
    else $error("bad guest state did not exit");
  AST_NO_RUN: assert property (s_bad_entry |=> !guest_running [*6])
    else $error("guest ran with bad state");
  AST_GIF: assert property (exit_wb_pulse |-> ##[0:2] !global_irq_flag)
    else $error("irq flag not cleared on exit");
  AST_CLR: assert property (exit_wb_pulse |-> ##[0:2] (!intercepts_on
    && cur_address_space_id == 32'h0000_0000 && !virt_irq
    && !virtual_irq_mask_ctl && timestamp_offset == 64'h0))
    else $error("exit did not clear guest controls");
  AST_FORCE: assert property (exit_wb_pulse |-> ##[0:3] (force_pe
    && !virtual8086_flag && current_privilege_level == 2'h0
    && debug_control_bp_en == 8'h00)) else $error("host mode not forced");
  AST_SHUT: assert property ((exit_wb_pulse && host_seg_fault)
    ##1 host_seg_fault [*3] |-> ##[0:2] shutdown)
    else $error("segment fault did not shut down");
  AST_STICKY: assert property (shutdown |=> shutdown)
    else $error("shutdown dropped");
  AST_CANON: assert property (seg_load ##1 (!seg_load &&
    $stable(seg_idx_in)) |=> seg_base_out == canon_reg)
    else $error("segment base not canonical");
endmodule
bind gws_world_switch gws_world_switch_props u_gws_world_switch_props (.*);

// File: gws_world_switch_test.sv
`timescale 1ns/1ns
module gws_world_switch_test;
  logic sys_clk, sys_rst, instr_valid, host_prot_mode, host_rf, host_tf;
  logic [1:0] instr_op, host_cpl, exc_raise, current_privilege_level;
  logic [63:0] host_efer, g_cr0, g_cr3, g_cr4, g_efer, g_dr6, g_dr7;
  logic g_cs_l, g_cs_d, g_rf, g_tf, entry_intercept_bit, inject_bad;
  logic [63:0] msr_tbl_end, io_tbl_end, seg_base_in, exit_reason, host_page_dir_pointer_entry;
  logic [63:0] exit_reason_field, timestamp_offset, seg_base_out, reason;
  logic [31:0] g_address_space_id, cur_address_space_id, rng;
  logic [2:0] seg_idx_in;
  logic [7:0] debug_control_bp_en, exit_delay;
  logic seg_load, guest_instr_done, exit_req, host_pae, host_seg_fault;
  logic host_state_bad, host_ip_bad, guest_running, global_irq_flag;
  logic exit_wb_pulse, xctx_move_pulse, xctx_dir_load, shutdown, host_gp;
  logic host_db_trap, host_rf_out, guest_bp_suppress, guest_trace_trap;
  logic intercepts_on, virt_irq, virtual_irq_mask_ctl, force_pe;
  logic virtual8086_flag;
  int n_errors, total_checks, cyc, i, k;
  gws_world_switch u_gws_world_switch (.*);
  gws_guest_model u_gws_guest_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic good();
    rng = xs(rng);
    {g_rf, g_tf, host_rf, host_tf, host_pae} = rng[4:0];
    g_cr0 = 64'h0000_0000_8000_0001;
    g_cr3 = {32'h0000_0000, rng & 32'hFFFF_F000};
    g_cr4 = 64'h0;
    g_efer = 64'h0000_0000_0000_1000;
    host_efer = g_efer;
    g_dr6 = {32'h0000_0000, rng};
    g_dr7 = 64'h0000_0000_0000_0400;
    {g_cs_l, g_cs_d, entry_intercept_bit, inject_bad} = 4'b0110;
    g_address_space_id = rng | 32'h0000_0001;
    msr_tbl_end = 64'h0000_0000_0001_0000;
    io_tbl_end = msr_tbl_end;
    {host_cpl, host_prot_mode} = 3'b001;
    reason = {54'h0, rng[9:0]};
    exit_delay = {5'h00, rng[12:10]} + 8'h02;
  endtask
  task automatic issue(input logic [1:0] op);
    @(negedge sys_clk);
    instr_op = op;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
  endtask
  task automatic entry(input logic ok, input logic [63:0] code);
    logic ran, seen, bp, trap;
    {ran, seen, bp, trap} = 4'h0;
    issue(gws_pkg::OP_ENTRY);
    chk("host_rf", {63'h0, host_rf}, {63'h0, host_rf_out});
    for (k = 0; k < 300 && exit_wb_pulse !== 1'b1; k++) begin
      ran = ran | guest_running;
      if (guest_running === 1'b1 && !seen) begin
        seen = 1'b1;
        bp = guest_bp_suppress;
      end
      trap = trap | guest_trace_trap;
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    chk("host_db", {63'h0, host_tf & ~host_seg_fault},
        {63'h0, host_db_trap});
    chk("host_rf_clr", 64'h0, {63'h0, host_rf_out});
    chk("host_gp", {63'h0, host_ip_bad & ~host_seg_fault},
        {63'h0, host_gp});
    chk("g_bp", {63'h0, g_rf & ok}, {63'h0, bp});
    chk("g_trap", {63'h0, g_tf & ok}, {63'h0, trap});
    repeat (3) @(negedge sys_clk);
    chk("ran", {63'h0, ok}, {63'h0, ran});
    chk("exit_code", code, exit_reason_field);
    chk("gif", 64'h0, {63'h0, global_irq_flag});
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////
  initial begin
    {n_errors, total_checks, cyc} = '0;
    rng = 32'habcf;
    good();
    {sys_rst, instr_valid, instr_op, seg_load, seg_idx_in} = 8'h80;
    {host_seg_fault, host_state_bad, host_ip_bad} = 3'b000;
    seg_base_in = 64'h0;
    host_page_dir_pointer_entry = 64'h0;
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk("gif_rst", 64'h1, {63'h0, global_irq_flag});
    chk("bp_rst", 64'hFF, {56'h0, debug_control_bp_en});
    for (i = 0; i < 9; i++) begin
      good();
      if (i / 3 == 0) host_cpl = rng[1:0] | 2'h1;
      if (i / 3 == 1) host_prot_mode = 1'b0;
      if (i / 3 == 2) host_efer = 64'h0;
      issue(2'(i % 3));
      chk("exc", (i < 3) ? 64'h1 : 64'h2, {62'h0, exc_raise});
      repeat (6) @(negedge sys_clk);
    end
    for (i = 1; i < 3; i++) begin
      good();
      issue(2'(i));
      for (k = 0; k < 8 && xctx_move_pulse !== 1'b1; k++) @(negedge sys_clk);
      chk("xmove", 64'h1, {63'h0, xctx_move_pulse});
      chk("xdir", 64'(i == 2), {63'h0, xctx_dir_load});
      repeat (4) @(negedge sys_clk);
    end
    for (i = 0; i < 8; i++) begin
      good();
      rng = xs(rng);
      seg_idx_in = 3'(i);
      seg_base_in = {rng, xs(rng)};
      seg_load = 1'b1;
      issue(gws_pkg::OP_LOAD);
      seg_load = 1'b0;
      @(negedge sys_clk);
      chk("seg", {{16{seg_base_in[47]}}, seg_base_in[47:0]}, seg_base_out);
    end
    for (i = 0; i < 16; i++) begin
      good();
      if (i > 7 && i < 11) g_efer[gws_pkg::LONG_MODE_ENABLE] = 1'b1;
      if (i > 8 && i < 11) g_cr4[gws_pkg::PHYS_ADDR_EXT_BIT] = 1'b1;
      case (i)
        0: g_efer[gws_pkg::VIRT_ENABLE_BIT] = 1'b0;
        1: g_cr0[gws_pkg::NO_WRITETHROUGH_BIT] = 1'b1;
        2: g_cr0[40] = 1'b1;
        3: g_dr6[63] = 1'b1;
        4: g_dr7[32] = 1'b1;
        5: g_cr3[63] = 1'b1;
        6: g_cr4[23] = 1'b1;
        7: g_efer[9] = 1'b1;
        9: g_cr0[gws_pkg::PROTECTION_ENABLE_BIT] = 1'b0;
        10: g_cs_l = 1'b1;
        11: entry_intercept_bit = 1'b0;
        12: g_address_space_id = 32'h0000_0000;
        13: inject_bad = 1'b1;
        14: msr_tbl_end = 64'h0010_0000_0000_0000;
        15: io_tbl_end = 64'h0010_0000_0000_0000;
        default: ; // Case 8 is long mode paging without PAE
      endcase
      entry(1'b0, gws_pkg::BAD_STATE_EXIT_CODE);
    end
    for (i = 0; i < 4; i++) begin
      good();
      if (i == 0) g_cr0[gws_pkg::PROTECTION_ENABLE_BIT] = 1'b0;
      host_ip_bad = (i == 3);
      entry(1'b1, reason);
    end
    good();
    host_seg_fault = 1'b1;
    entry(1'b1, reason);
    chk("shutdown", 64'h1, {63'h0, shutdown});
    summarize();
  end
endmodule
